// ==== verilog/lrx_consts.vh ====
// Constants for the receive output control block
`ifndef LRX_CONSTS_VH
`define LRX_CONSTS_VH
`define LRX_CHANNELS        3
`define LRX_INV_RESET_VAL   1'b0
`define LRX_EQ_RESET_VAL    1'b0
`define LRX_DEC_RESET_VAL   1'b1
`define LRX_SUB_WINDOW      4
`endif

// ==== verilog/lrx_channel.v ====
// One receive channel: line clock sync, edge find and clock output
`timescale 1ns/1ps
`include "lrx_consts.vh"
module lrx_channel (
    input  wire clk,
    input  wire reset_n,
    input  wire line_clock_in,
    input  wire invert_clock,
    output wire clock_rise,
    output reg  recovered_clock_out
);
    reg [1:0] clk_sync_q;
    reg       clk_prev_q;

    // Rails move on the raw line clock rise: the rising output edge,
    // or the falling one when the output is inverted
    assign clock_rise = clk_sync_q[1] & ~clk_prev_q;

    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            clk_sync_q          <= 2'h0;
            clk_prev_q          <= 1'h0;
            recovered_clock_out <= 1'h0;
        end else begin
            clk_sync_q          <= {clk_sync_q[0], line_clock_in};
            clk_prev_q          <= clk_sync_q[1];
            // Inverted clock when selected
            recovered_clock_out <= clk_sync_q[1] ^ invert_clock;
        end
    end
endmodule

// ==== verilog/lrx_output_control.v ====
// Top of the receive output and configuration control, three channels
// Overview of operation
// - Positive line pulse drives positive rail high for that bit.
// - With decoder on, substitution codes never reach either rail.
// - Negative line pulse drives negative rail high for that bit.
// - Invert select low: rails update on rising edge of recovered clock.
// - Invert select high: clock inverted, rails update on its falling edge.
// - Host mode: shared select low resets command registers and config.
// - Undriven shared select reads high.
// - Hardware mode: equalizer enable input directly gates equalizer.
// - Host mode ignores equalizer inputs; they should be tied low.
// - Host mode: command register invert bit selects falling edge.
`timescale 1ns/1ps
`include "lrx_consts.vh"
module lrx_output_control #(
    parameter CHANNELS = `LRX_CHANNELS
) (
    input  wire                clk,
    input  wire                reset_n,
    input  wire                host_mode,
    input  wire                select_in,
    input  wire                select_driven,
    input  wire [CHANNELS-1:0] line_input_positive_leg,
    input  wire [CHANNELS-1:0] line_input_negative_leg,
    input  wire [CHANNELS-1:0] line_clock_in,
    input  wire [CHANNELS-1:0] rx_equalizer_enable_in,
    input  wire                cmd_write,
    input  wire                cmd_clock_invert,
    input  wire [CHANNELS-1:0] cmd_equalizer_enable,
    input  wire [CHANNELS-1:0] cmd_decoder_enable,
    output wire [CHANNELS-1:0] rx_positive_rail_out,
    output wire [CHANNELS-1:0] rx_negative_rail_out,
    output wire [CHANNELS-1:0] recovered_clock_out,
    output reg  [CHANNELS-1:0] equalizer_enable_out,
    output wire                command_register_reset_n
);
    reg [1:0]          sel_sync_q;
    reg [1:0]          mode_sync_q;
    reg [CHANNELS-1:0] eq_sync0_q;
    reg [CHANNELS-1:0] eq_sync1_q;
    reg                inv_q;
    reg [CHANNELS-1:0] eq_q;
    reg [CHANNELS-1:0] dec_q;
    wire               sel_level;
    wire               rx_clock_invert_select;
    wire               invert;

    // Floating select reads high
    assign sel_level                = select_driven ? select_in : 1'b1;
    assign command_register_reset_n = ~mode_sync_q[1] | sel_sync_q[1];
    assign rx_clock_invert_select   = sel_sync_q[1];
    // Hardware pin or host command bit picks the edge
    assign invert = mode_sync_q[1] ? inv_q : rx_clock_invert_select;

    // Mode and select pins pass two flops
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_sync_q  <= 2'h3;
            mode_sync_q <= 2'h0;
        end else begin
            sel_sync_q  <= {sel_sync_q[0], sel_level};
            mode_sync_q <= {mode_sync_q[0], host_mode};
        end
    end

    // Equalizer pins pass two flops
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            eq_sync0_q <= {CHANNELS{1'b0}};
            eq_sync1_q <= {CHANNELS{1'b0}};
        end else begin
            eq_sync0_q <= rx_equalizer_enable_in;
            eq_sync1_q <= eq_sync0_q;
        end
    end

    // Command registers
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            inv_q <= `LRX_INV_RESET_VAL;
            eq_q  <= {CHANNELS{`LRX_EQ_RESET_VAL}};
            dec_q <= {CHANNELS{`LRX_DEC_RESET_VAL}};
        end else if (!command_register_reset_n) begin
            inv_q <= `LRX_INV_RESET_VAL;
            eq_q  <= {CHANNELS{`LRX_EQ_RESET_VAL}};
            dec_q <= {CHANNELS{`LRX_DEC_RESET_VAL}};
        end else if (cmd_write) begin
            inv_q <= cmd_clock_invert;
            eq_q  <= cmd_equalizer_enable;
            dec_q <= cmd_decoder_enable;
        end
    end

    // Equalizer pins count only in hardware mode
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            equalizer_enable_out <= {CHANNELS{1'b0}};
        end else begin
            equalizer_enable_out <= mode_sync_q[1] ? eq_q : eq_sync1_q;
        end
    end

    localparam HIST = `LRX_SUB_WINDOW;

    // Per-channel line data path: synchronise, decode, drive the rails
    genvar g;
    generate
        for (g = 0; g < CHANNELS; g = g + 1) begin : ch
            reg [1:0]      pos_sync_q;
            reg [1:0]      neg_sync_q;

            reg [HIST-1:0] pos_hist_q;
            reg [HIST-1:0] neg_hist_q;
            reg            last_pol_q;

            reg            pos_rail_q;
            reg            neg_rail_q;

            reg [HIST-1:0] pos_d;
            reg [HIST-1:0] neg_d;
            reg            last_pol_d;
            reg            pos_rail_d;
            reg            neg_rail_d;

            wire           pos_bit;
            wire           neg_bit;
            wire           pulse;
            wire           violation;
            wire           gap_before;
            wire           rise;

            // Recovered clock output and the edge that moves the rails
            lrx_channel u_ch (
                .clk                 (clk),
                .reset_n             (reset_n),
                .line_clock_in       (line_clock_in[g]),
                .invert_clock        (invert),
                .clock_rise          (rise),
                .recovered_clock_out (recovered_clock_out[g])
            );

            // Line pulses cross into the clock domain through two flops
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    pos_sync_q <= 2'h0;
                    neg_sync_q <= 2'h0;
                end else begin
                    pos_sync_q <= {pos_sync_q[0],
                                   line_input_positive_leg[g]};
                    neg_sync_q <= {neg_sync_q[0],
                                   line_input_negative_leg[g]};
                end
            end

            assign pos_bit    = pos_sync_q[1];
            assign neg_bit    = neg_sync_q[1];
            assign pulse      = pos_bit | neg_bit;
            // Same polarity as the previous pulse marks a substituted code
            assign violation  = pulse & (pos_bit == last_pol_q);
            assign gap_before = ~(pos_hist_q[0] | neg_hist_q[0]);

            // New bit enters at index 0; the top index is the oldest
            always @* begin
                pos_d      = {pos_hist_q[HIST-2:0], pos_bit};
                neg_d      = {neg_hist_q[HIST-2:0], neg_bit};
                last_pol_d = last_pol_q;
                if (pulse) begin
                    last_pol_d = pos_bit;
                end
                if (dec_q[g] && violation && gap_before) begin
                    // Code with a gap before the violation leaves whole
                    pos_d = {HIST{1'h0}};
                    neg_d = {HIST{1'h0}};
                end else if (dec_q[g] && violation) begin
                    // Pulse then violation: both leave
                    pos_d[1:0] = 2'h0;
                    neg_d[1:0] = 2'h0;
                end
            end

            // Decoder off passes every pulse straight through
            always @* begin
                if (dec_q[g]) begin
                    pos_rail_d = pos_hist_q[HIST-1];
                    neg_rail_d = neg_hist_q[HIST-1];
                end else begin
                    pos_rail_d = pos_bit;
                    neg_rail_d = neg_bit;
                end
            end

            // History and polarity advance once per line bit
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    pos_hist_q <= {HIST{1'h0}};
                    neg_hist_q <= {HIST{1'h0}};
                    last_pol_q <= 1'h0;
                end else if (rise) begin
                    pos_hist_q <= pos_d;
                    neg_hist_q <= neg_d;
                    last_pol_q <= last_pol_d;
                end
            end

            // Rails move on the edge that moves the output clock
            always @(posedge clk or negedge reset_n) begin
                if (!reset_n) begin
                    pos_rail_q <= 1'h0;
                    neg_rail_q <= 1'h0;
                end else if (rise) begin
                    pos_rail_q <= pos_rail_d;
                    neg_rail_q <= neg_rail_d;
                end
            end

            // Rail outputs come straight from flops
            assign rx_positive_rail_out[g] = pos_rail_q;
            assign rx_negative_rail_out[g] = neg_rail_q;
        end
    endgenerate
endmodule

// ==== test/lrx_output_control_sva.sv ====
// Checker of the receive output control ports
`timescale 1ns/1ps
module lrx_output_control_sva (
    input wire       clk,
    input wire       reset_n,
    input wire       host_mode,
    input wire       select_in,
    input wire       select_driven,
    input wire [2:0] line_clock_in,
    input wire [2:0] rx_equalizer_enable_in,
    input wire       cmd_write,
    input wire [2:0] rx_positive_rail_out,
    input wire [2:0] rx_negative_rail_out,
    input wire [2:0] recovered_clock_out,
    input wire [2:0] equalizer_enable_out,
    input wire       command_register_reset_n
);
    reg  [1:0] ck_q;
    wire       inv = select_in | ~select_driven;
    wire       act = (ck_q[0] != recovered_clock_out[0]
        && recovered_clock_out[0] == ~inv)
        || (ck_q[1] != ck_q[0] && ck_q[0] == ~inv);
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) ck_q <= 2'h0;
        else ck_q <= {ck_q[0], recovered_clock_out[0]};
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_cmd_reset_low: assert property ((host_mode && select_driven
        && !select_in)[*4] |-> !command_register_reset_n)
        else $error("register reset not applied");
    a_float_no_reset: assert property ((host_mode
        && !select_driven)[*4] |-> command_register_reset_n)
        else $error("floating select caused register reset");
    a_reset_clears_eq: assert property ((host_mode
        && !command_register_reset_n)[*3] |-> equalizer_enable_out == 3'h0)
        else $error("equalizer not cleared by register reset");
    a_eq_follows_pin: assert property ((!host_mode
        && $stable(rx_equalizer_enable_in))[*5]
        |-> equalizer_enable_out == rx_equalizer_enable_in)
        else $error("equalizer output does not follow pin");
    a_eq_pin_ignored: assert property ((host_mode && !cmd_write
        && command_register_reset_n)[*5] |-> $stable(equalizer_enable_out))
        else $error("equalizer changed without command write");
    a_rail_edge_only: assert property ((!host_mode
        && $stable(inv))[*6]
        ##0 $changed({rx_positive_rail_out[0], rx_negative_rail_out[0]})
        |-> act)
        else $error("rail changed off the active clock edge");
    a_clock_plain: assert property ((!host_mode && !inv)[*8]
        ##0 $rose(line_clock_in[0]) |-> ##[1:5] recovered_clock_out[0])
        else $error("recovered clock not following line clock");
    a_clock_inverted: assert property ((!host_mode && inv)[*8]
        ##0 $rose(line_clock_in[0]) |-> ##[1:5] !recovered_clock_out[0])
        else $error("recovered clock not inverted");
endmodule

// ==== test/lrx_framer_model.sv ====
// Framer model counting rail marks of channel 0
`timescale 1ns/1ps
module lrx_framer_model (
    input wire clk,
    input wire recovered_clock,
    input wire pos_rail,
    input wire neg_rail
);
    reg [2:0] ck_q = 3'h0;
    integer   pos_count = 0;
    integer   neg_count = 0;
    // Sample three cycles after each rise, clear of any update edge
    always @(posedge clk) begin
        ck_q <= {ck_q[1:0], recovered_clock};
        if (ck_q[2:1] == 2'h1) begin
            pos_count <= pos_count + pos_rail;
            neg_count <= neg_count + neg_rail;
        end
    end
endmodule

// ==== test/lrx_output_control_test.sv ====
// Bench for the receive output and configuration control
`timescale 1ns/1ps
module lrx_output_control_test;
    reg         clk = 0, reset_n = 0, lclk = 0, pol = 0, cmd_write = 0;
    reg         host_mode = 0, select_in = 0, select_driven = 1;
    reg         cmd_clock_invert = 0;
    reg  [2:0]  line_input_positive_leg = 0, line_input_negative_leg = 0;
    reg  [2:0]  rx_equalizer_enable_in = 0, cmd_equalizer_enable = 0;
    reg  [2:0]  cmd_decoder_enable = 0;
    wire [2:0]  line_clock_in, rx_positive_rail_out, rx_negative_rail_out;
    wire [2:0]  recovered_clock_out, equalizer_enable_out;
    wire        command_register_reset_n;
    reg  [31:0] seed = 32'hFCAF1622;
    integer     errors = 0, checks_done = 0, i, ep = 0, en = 0;
    lrx_output_control uut (
        .clk                      (clk),
        .reset_n                  (reset_n),
        .host_mode                (host_mode),
        .select_in                (select_in),
        .select_driven            (select_driven),
        .line_input_positive_leg  (line_input_positive_leg),
        .line_input_negative_leg  (line_input_negative_leg),
        .line_clock_in            (line_clock_in),
        .rx_equalizer_enable_in   (rx_equalizer_enable_in),
        .cmd_write                (cmd_write),
        .cmd_clock_invert         (cmd_clock_invert),
        .cmd_equalizer_enable     (cmd_equalizer_enable),
        .cmd_decoder_enable       (cmd_decoder_enable),
        .rx_positive_rail_out     (rx_positive_rail_out),
        .rx_negative_rail_out     (rx_negative_rail_out),
        .recovered_clock_out      (recovered_clock_out),
        .equalizer_enable_out     (equalizer_enable_out),
        .command_register_reset_n (command_register_reset_n)
    );
    lrx_framer_model fm (.clk(clk), .recovered_clock(recovered_clock_out[0]),
        .pos_rail(rx_positive_rail_out[0]), .neg_rail(rx_negative_rail_out[0]));
    always #25 clk = ~clk;
    initial begin #7; forever #200 lclk = ~lclk; end
    assign line_clock_in = {3{lclk}};
    function [31:0] xs(input [31:0] s);
        reg [31:0] t;
        begin t = s ^ (s << 13); t = t ^ (t >> 17); xs = t ^ (t << 5); end
    endfunction
    task check(input [31:0] seen, input [31:0] exp);
        begin
            checks_done = checks_done + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task final_report;
        begin
            $display("Checks %0d, mismatches %0d", checks_done, errors);
            if (errors == 0 && checks_done > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    task send(input p, input n, input cnt);
        begin
            @(negedge lclk); @(negedge clk); seed = xs(seed);
            line_input_positive_leg = {seed[2:1], p};
            line_input_negative_leg = {seed[4:3] & ~seed[2:1], n};
            if (cnt) begin ep = ep + p; en = en + n; end
        end
    endtask
    task mark(input cnt);
        begin pol = ~pol; send(pol, ~pol, cnt); end
    endtask
    task clk_chk(input e);
        begin
            @(posedge lclk);
            repeat (5) @(negedge clk);
            check(recovered_clock_out, {3{e}});
        end
    endtask
    task wr;
        begin @(negedge clk); cmd_write = 1; @(negedge clk); cmd_write = 0; end
    endtask
    task tally;
        begin
            for (i = 0; i < 7; i = i + 1) send(0, 0, 0);
            check(fm.pos_count, ep); check(fm.neg_count, en);
        end
    endtask
    initial begin #300000; errors = errors + 1; final_report; end
    initial begin
        repeat (5) @(negedge clk);
        reset_n = 1;
        clk_chk(1'h1);
        for (i = 0; i < 24; i = i + 1) begin
            seed = xs(seed);
            if (seed[7]) mark(1); else send(0, 0, 0);
        end
        send(0, 0, 0); send(0, 0, 0); send(0, 0, 0); send(pol, ~pol, 0);
        mark(0); send(0, 0, 0); send(0, 0, 0); send(pol, ~pol, 0);
        tally;
        $display("Test 1 done");
        select_in = 1; clk_chk(1'h0);
        select_in = 0; select_driven = 0; clk_chk(1'h0);
        rx_equalizer_enable_in = seed[2:0]; repeat (6) @(negedge clk);
        check(equalizer_enable_out, rx_equalizer_enable_in);
        $display("Test 2 done");
        host_mode = 1; select_driven = 1; select_in = 1;
        rx_equalizer_enable_in = 0; repeat (4) @(negedge clk);
        cmd_clock_invert = 1; cmd_equalizer_enable = 3'h5; wr;
        rx_equalizer_enable_in = 3'h2; repeat (6) @(negedge clk);
        check(equalizer_enable_out, 3'h5);
        clk_chk(1'h0);
        mark(1); send(0, 0, 0); send(0, 0, 0);
        send(0, 0, 0); send(pol, ~pol, 1);
        tally;
        $display("Test 3 done");
        select_in = 0; repeat (4) @(negedge clk);
        check(command_register_reset_n, 1'h0);
        check(equalizer_enable_out, 3'h0);
        select_in = 1; clk_chk(1'h1);
        select_driven = 0; repeat (6) @(negedge clk);
        check(command_register_reset_n, 1'h1);
        $display("Test 4 done");
        final_report;
    end
endmodule
bind lrx_output_control lrx_output_control_sva chk (
    .clk                      (clk),
    .reset_n                  (reset_n),
    .host_mode                (host_mode),
    .select_in                (select_in),
    .select_driven            (select_driven),
    .line_clock_in            (line_clock_in),
    .rx_equalizer_enable_in   (rx_equalizer_enable_in),
    .cmd_write                (cmd_write),
    .rx_positive_rail_out     (rx_positive_rail_out),
    .rx_negative_rail_out     (rx_negative_rail_out),
    .recovered_clock_out      (recovered_clock_out),
    .equalizer_enable_out     (equalizer_enable_out),
    .command_register_reset_n (command_register_reset_n)
);
